// file: common/flash_prot_defs.vh
`ifndef FLASH_PROT_DEFS_VH
`define FLASH_PROT_DEFS_VH

// Command opcodes
`define OP_READ_PROT 8'h3C
`define OP_READ_STATUS 8'h05
`define OP_WRITE_STATUS 8'h01
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_PROTECT_SECTOR 8'h36
`define OP_UNPROTECT_SECTOR 8'h39

// Status byte field positions
`define ST_LOCK_BIT 7
`define ST_RSVD_BIT 6
`define ST_FAIL_BIT 5
`define ST_GUARD_BIT 4
`define ST_SUMMARY_HI 3
`define ST_SUMMARY_LO 2
`define ST_WEL_BIT 1
`define ST_BUSY_BIT 0

// Protection summary encodings
`define SUMMARY_NONE 2'h0
`define SUMMARY_SOME 2'h1
`define SUMMARY_ALL 2'h3

// Global protect / unprotect selectors on bits 5:2
`define GLOBAL_UNPROTECT 4'h0
`define GLOBAL_PROTECT 4'hF

// Answer bytes of the sector protection read
`define PROT_BYTE_SET 8'hFF
`define PROT_BYTE_CLR 8'h00

// Reset values
`define LOCK_RESET 1'b0
`define FLAGS_RESET 1'b1
`define WEL_RESET 1'b0

// Address bytes after the sector read opcode
`define ADDR_BYTES 3

`endif

// file: rtl/pin_sync.v
`timescale 1ns/1ns
`default_nettype none

// Two-flop synchroniser for a bundle of pin levels
module pin_sync #(
    parameter WIDTH = 4,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    input wire i_clk_sys,
    input wire i_rst_n,
    input wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);

reg [WIDTH-1:0] meta_reg;
reg [WIDTH-1:0] sync_reg;

// First stage is read only by the second
always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
        meta_reg <= INIT;
        sync_reg <= INIT;
    end else begin
        meta_reg <= i_async;
        sync_reg <= meta_reg;
    end
end

assign o_sync = sync_reg;

endmodule // pin_sync

`default_nettype wire

// file: rtl/serial_shifter.v
`timescale 1ns/1ns
`default_nettype none

// Serial byte receiver framed by chip select; reports whole bytes
module serial_shifter (
    input wire i_clk_sys,
    input wire i_rst_n,
    input wire i_sel,
    input wire i_rise,
    input wire i_din,
    output reg o_byte_done,
    output reg [7:0] o_byte,
    output reg [2:0] o_bit_cnt
);

reg [6:0] shift_reg;

// Bits enter MSB first on rising clock edges; counter clears while idle
always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
        shift_reg <= 7'h00;
        o_bit_cnt <= 3'h0;
        o_byte_done <= 1'b0;
        o_byte <= 8'h00;
    end else begin
        o_byte_done <= 1'b0;
        if (!i_sel) begin
            o_bit_cnt <= 3'h0;
        end else if (i_rise) begin
            shift_reg <= {shift_reg[5:0], i_din};
            o_bit_cnt <= o_bit_cnt + 3'h1;
            if (o_bit_cnt == 3'h7) begin
                o_byte <= {shift_reg, i_din};
                o_byte_done <= 1'b1;
            end
        end
    end
end

endmodule // serial_shifter

`default_nettype wire

// file: rtl/flash_protection_status.v
`timescale 1ns/1ns
`default_nettype none

`include "flash_prot_defs.vh"

// What this block does
// - Opcode 3Ch plus three address bytes
// - Answer repeats FFh protected, 00h unprotected
// - Chip select high ends sector read
// - Guard pin never touches array protection directly
// - Pin low and lock set freezes flags and lock
// - Hard lock ignores protect, unprotect, status write
// - Unlocking write performs no global change
// - Pin low: lock cleared only by reset
// - Pin high: lock set rejects sector commands
// - Lock 0 to 1 applies global selection
// - Lock change permissions by pin level
// - Opcode 05h then status bits follow
// - Status byte repeats, freshly sampled each time
// - Status read allowed while busy
// - Chip select high ends status read
// - Bit 7 lock, bit 6 reads zero
// - Bit 5 reports program or erase failure
// - Bit 4 mirrors guard pin level
// - Bits 3:2 summarise protection flags
// - Bit 1 reports write enable latch
// - Bit 0 reports operation in progress
// - Status write changes only bit 7
// - Status write opcode 01h, applied at deselect
// - Lock bit cleared at reset
// - Unlocked 00h unprotects all, 7Fh protects all
module flash_protection_status #(
    parameter SECTORS = 16,
    parameter SECT_BITS = 4,
    parameter ADDR_BITS = 24
) (
    input wire i_clk_sys,
    input wire i_rst_n,
    input wire i_sck,
    input wire i_cs_n,
    input wire i_si,
    input wire i_guard_n,
    input wire i_op_in_progress,
    input wire i_program_fail_flag,
    output reg o_so,
    output reg o_so_oe,
    output reg [SECTORS-1:0] o_protect_flags,
    output reg o_protect_flags_lock,
    output reg o_write_enable_latch
);

// Command sequencer states, one flop each; a stray code falls back to
// waiting for an opcode through the default branch
localparam [4:0] ST_OPCODE = 5'h01;
localparam [4:0] ST_ADDR = 5'h02;
localparam [4:0] ST_SEND = 5'h04;
localparam [4:0] ST_WDATA = 5'h08;
localparam [4:0] ST_IGNORE = 5'h10;

localparam [1:0] MODE_NONE = 2'h0;
localparam [1:0] MODE_STATUS = 2'h1;
localparam [1:0] MODE_PROT = 2'h2;

// Index of the last address byte, sized to the byte counter
localparam [1:0] ADDR_LAST = `ADDR_BYTES - 1;

// Summary of flags into the two-bit code
// The reserved code never comes out: some, all or none covers all cases
function [1:0] summarise;
    input [SECTORS-1:0] flags;
    begin
        if (&flags)
            summarise = `SUMMARY_ALL;
        else if (|flags)
            summarise = `SUMMARY_SOME;
        else
            summarise = `SUMMARY_NONE;
    end
endfunction

// Synchronised pin copies and the edges found in them
wire [3:0] pins_sync;
wire sck_s;
wire cs_n_s;
wire si_s;
wire guard_n_s;
reg sck_prev_reg;
wire sel;
wire rise;
wire fall;
wire byte_done;
wire [7:0] rx_byte;
wire [2:0] bit_cnt;
// Sequencer state and the command being served
reg [4:0] state_reg;
reg [1:0] mode_reg;
reg [1:0] addr_cnt_reg;
reg [ADDR_BITS-1:0] addr_reg;
reg [7:0] tx_reg;
reg [2:0] tx_idx_reg;
// Status write capture, applied only at deselect
reg [7:0] wdata_reg;
reg wdata_ok_reg;
reg wstat_pending_reg;
reg cs_prev_reg;
wire hard_lock;
wire [7:0] status_now;
wire [SECT_BITS-1:0] sect_idx;
wire deselect;
// Decoded events shared by the sequencer and the flag logic
wire opcode_done;
wire sect_flag;
wire wstat_whole;
wire wstat_commit;
wire [3:0] global_sel;

// Pins cross into the system clock through two flops
// Reset values are clock high, select high, data low,
// guard high; anything else would fake an edge or a frame at release
pin_sync #(
    .WIDTH(4),
    .INIT(4'hD)
) u_pin_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_async({i_sck, i_cs_n, i_si, i_guard_n}),
    .o_sync(pins_sync)
);

assign sck_s = pins_sync[3];
assign cs_n_s = pins_sync[2];
assign si_s = pins_sync[1];
assign guard_n_s = pins_sync[0];
// Edges lag the pins by about three system clocks; the serial clock
// must stay in each phase longer than that or edges are lost
assign sel = !cs_n_s;
assign rise = sel && sck_s && !sck_prev_reg;
assign fall = sel && !sck_s && sck_prev_reg;
assign deselect = cs_n_s && !cs_prev_reg;

// Hard lock needs pin asserted and lock set; the pin alone guards nothing
assign hard_lock = !guard_n_s && o_protect_flags_lock;

// Live status byte, sampled anew for every repetition
assign status_now = {o_protect_flags_lock, 1'b0, i_program_fail_flag,
    guard_n_s, summarise(o_protect_flags), o_write_enable_latch,
    i_op_in_progress};

// Sector chosen by the top address bits
assign sect_idx = addr_reg[ADDR_BITS-1 -: SECT_BITS];
assign sect_flag = o_protect_flags[sect_idx];

// A whole opcode byte has arrived in a live frame
assign opcode_done = state_reg == ST_OPCODE && byte_done && sel;

// A status write is only taken whole: data byte in and select raised
// on a byte boundary; anything else aborts but still drops the latch
assign wstat_whole = wdata_ok_reg && (bit_cnt == 3'h0);
// Hard lock swallows the write entirely, lock bit included
assign wstat_commit = deselect && wstat_pending_reg && wstat_whole
    && o_write_enable_latch && !hard_lock;
// Bits 5:2 are decoded, never stored; they pick the global action
assign global_sel = wdata_reg[5:2];

// Bytes arrive whole; the bit count also tells where select rose
serial_shifter u_shifter (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_sel(sel),
    .i_rise(rise),
    .i_din(si_s),
    .o_byte_done(byte_done),
    .o_byte(rx_byte),
    .o_bit_cnt(bit_cnt)
);

// Edge history of the sampled clock and select
always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
        sck_prev_reg <= 1'b1;
        cs_prev_reg <= 1'b1;
    end else begin
        sck_prev_reg <= sck_s;
        cs_prev_reg <= cs_n_s;
    end
end

// Command sequencer; answers go out on falling edges (mode 0 and 3)
// Only one command per frame: after it the sequencer either answers,
// collects data or idles until select rises again
always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
        state_reg <= ST_OPCODE;
        mode_reg <= MODE_NONE;
        addr_cnt_reg <= 2'h0;
        addr_reg <= {ADDR_BITS{1'b0}};
        tx_reg <= 8'h00;
        tx_idx_reg <= 3'h7;
        wdata_reg <= 8'h00;
        wdata_ok_reg <= 1'b0;
        wstat_pending_reg <= 1'b0;
        o_so <= 1'b0;
        o_so_oe <= 1'b0;
    end else if (!sel) begin
        // Deselect at any bit ends the read and floats the output
        state_reg <= ST_OPCODE;
        mode_reg <= MODE_NONE;
        addr_cnt_reg <= 2'h0;
        tx_idx_reg <= 3'h7;
        o_so_oe <= 1'b0;
        o_so <= 1'b0;
        wstat_pending_reg <= 1'b0;
    end else begin
        case (state_reg)
            ST_OPCODE: begin
                if (byte_done) begin
                    case (rx_byte)
                        `OP_READ_STATUS: begin
                            // Accepted even while busy
                            state_reg <= ST_SEND;
                            mode_reg <= MODE_STATUS;
                            tx_reg <= status_now;
                        end
                        `OP_READ_PROT: begin
                            state_reg <= ST_ADDR;
                        end
                        `OP_WRITE_STATUS: begin
                            state_reg <= ST_WDATA;
                            wdata_ok_reg <= 1'b0;
                            wstat_pending_reg <= 1'b1;
                        end
                        default: begin
                            state_reg <= ST_IGNORE;
                        end
                    endcase
                end
            end
            ST_ADDR: begin
                if (byte_done) begin
                    addr_reg <= {addr_reg[ADDR_BITS-9:0], rx_byte};
                    addr_cnt_reg <= addr_cnt_reg + 2'h1;
                    if (addr_cnt_reg == ADDR_LAST) begin
                        state_reg <= ST_SEND;
                        mode_reg <= MODE_PROT;
                    end
                end
            end
            ST_SEND: begin
                // Sector answer follows the flag live; all bits equal,
                // so reloading mid-byte cannot tear the pattern
                if (mode_reg == MODE_PROT)
                    tx_reg <= sect_flag ?
                        `PROT_BYTE_SET : `PROT_BYTE_CLR;
                if (fall) begin
                    o_so_oe <= 1'b1;
                    o_so <= tx_reg[tx_idx_reg];
                    tx_idx_reg <= tx_idx_reg - 3'h1;
                    // Reload fresh status after bit 0 goes out
                    if (tx_idx_reg == 3'h0 && mode_reg == MODE_STATUS)
                        tx_reg <= status_now;
                end
            end
            ST_WDATA: begin
                // First data byte kept; further bytes are ignored
                if (byte_done) begin
                    if (!wdata_ok_reg)
                        wdata_reg <= rx_byte;
                    wdata_ok_reg <= 1'b1;
                end
            end
            ST_IGNORE: begin
                // Unknown opcode: sit out the rest of the frame
                state_reg <= ST_IGNORE;
            end
            default: begin
                state_reg <= ST_OPCODE;
            end
        endcase
    end
end

// Protection flags, lock bit and write enable latch
// Flags and lock move only at deselect, so a frame in flight never
// sees the state it reports change under it
always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
        o_protect_flags <= {SECTORS{`FLAGS_RESET}};
        o_protect_flags_lock <= `LOCK_RESET;
        o_write_enable_latch <= `WEL_RESET;
    end else begin
        if (opcode_done) begin
            // Single-byte commands taken once the opcode is whole
            if (rx_byte == `OP_WRITE_ENABLE)
                o_write_enable_latch <= 1'b1;
            else if (rx_byte == `OP_WRITE_DISABLE)
                o_write_enable_latch <= 1'b0;
        end
        // Any status write that got its opcode in drops the latch
        if (deselect && wstat_pending_reg)
            o_write_enable_latch <= 1'b0;
        // Commit only when the latch is set; wstat_commit checks it
        if (wstat_commit) begin
            if (!o_protect_flags_lock) begin
                // Only bit 7 stored; 0 to 1 allowed at any pin level
                o_protect_flags_lock <= wdata_reg[`ST_LOCK_BIT];
                // Global action decoded from bits 5:2 while unlocked
                if (global_sel == `GLOBAL_UNPROTECT)
                    o_protect_flags <= {SECTORS{1'b0}};
                else if (global_sel == `GLOBAL_PROTECT)
                    o_protect_flags <= {SECTORS{1'b1}};
                // Other codes leave every flag as it stands
            end else begin
                // Soft lock: only unlock, never a global change
                o_protect_flags_lock <= wdata_reg[`ST_LOCK_BIT];
            end
        end
    end
end

endmodule // flash_protection_status

`default_nettype wire

// file: testbench/flash_protection_status_asserts.sv
`timescale 1ns/1ns
`default_nettype none
// Port-level checks of the protection and status block
module flash_prot_asserts #(
    parameter SECTORS = 16
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_guard_n,
    input wire logic o_so,
    input wire logic o_so_oe,
    input wire logic [SECTORS-1:0] o_protect_flags,
    input wire logic o_protect_flags_lock,
    input wire logic o_write_enable_latch
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);
    // Deselect floats the output once it crosses the synchroniser
    a_oe_after_deselect: assert property (
        i_cs_n [*5] |-> !o_so_oe) else $error("output driven deselected");
    a_oe_starts_sck_low: assert property (
        $rose(o_so_oe) |-> !i_cs_n && !i_sck) else $error("bad drive start");
    a_so_moves_sck_low: assert property (
        o_so_oe && $changed(o_so) |-> !i_sck && !$past(i_sck))
        else $error("output moved with clock high");
    a_reset_defaults: assert property (
        $rose(i_rst_n) |-> !o_protect_flags_lock && (&o_protect_flags)
        && !o_write_enable_latch) else $error("bad reset state");
    // State moves only after deselect, and only when write enabled
    a_update_deselected: assert property (
        $changed(o_protect_flags) || $changed(o_protect_flags_lock)
        |-> i_cs_n && $past(i_cs_n, 2) && $past(o_write_enable_latch))
        else $error("update outside deselect");
    a_global_only_open: assert property (
        $changed(o_protect_flags) |-> !$past(o_protect_flags_lock)
        && ((&o_protect_flags) || !(|o_protect_flags)))
        else $error("flags changed while locked");
    a_hard_lock_freeze: assert property (
        (!i_guard_n && o_protect_flags_lock) [*4] |=>
        $stable(o_protect_flags) && o_protect_flags_lock)
        else $error("hard lock not held");
    a_unlock_pin_high: assert property (
        $fell(o_protect_flags_lock) |-> i_guard_n && $past(i_guard_n, 8))
        else $error("lock cleared with pin low");
endmodule // flash_prot_asserts

bind flash_protection_status flash_prot_asserts #(.SECTORS(SECTORS)) i_chk (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_sck(i_sck),
    .i_cs_n(i_cs_n), .i_guard_n(i_guard_n), .o_so(o_so),
    .o_so_oe(o_so_oe), .o_protect_flags(o_protect_flags),
    .o_protect_flags_lock(o_protect_flags_lock),
    .o_write_enable_latch(o_write_enable_latch));
`default_nettype wire

// file: testbench/spi_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// Host of the serial bus, mode 0; clock stands low between frames
module spi_host_model (
    input wire logic i_clk_sys,
    input wire logic i_so,
    input wire logic i_so_oe,
    output logic o_sck,
    output logic o_cs_n,
    output logic o_si
);
    int slow = 0;
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b0;
    end
    // Shifts nb bits MSB first; answer bit read just before each rise
    task automatic run(input int nb, input logic [63:0] tx,
        output logic [63:0] rx);
        rx = '0;
        @(posedge i_clk_sys) o_cs_n <= 1'b0;
        for (int i = nb - 1; i >= 0; i--) begin
            o_si <= tx[i];
            repeat (5 + slow) @(posedge i_clk_sys);
            rx[i] = i_so_oe ? i_so : 1'bx;
            o_sck <= 1'b1;
            repeat (3) @(posedge i_clk_sys);
            o_sck <= 1'b0;
        end
        repeat (5) @(posedge i_clk_sys);
        o_cs_n <= 1'b1;
        o_si <= ~o_si; // Released line must not look like valid data
        repeat (6) @(posedge i_clk_sys);
    endtask
endmodule // spi_host_model
`default_nettype wire

// file: testbench/flash_protection_status_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "flash_prot_defs.vh"
module flash_protection_status_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic guard_n = 1'b1;
    logic busy = 1'b0;
    logic fail = 1'b0;
    logic exp_lock = 1'b0;
    logic exp_wel = 1'b0;
    logic [15:0] exp_flags = 16'hFFFF;
    logic [63:0] rx;
    logic [7:0] cor [5] = '{8'h7F, 8'h00, 8'hF0, 8'h3C, 8'hFF};
    int n_mismatch = 0;
    int num_checks = 0;
    wire sck, cs_n, si, so, so_oe, lock, write_enable_latch;
    wire [15:0] flags;
    initial forever #10 clk = ~clk;
    flash_protection_status i_dut (.i_clk_sys(clk), .i_rst_n(rst_n),
        .i_sck(sck), .i_cs_n(cs_n), .i_si(si), .i_guard_n(guard_n),
        .i_op_in_progress(busy), .i_program_fail_flag(fail), .o_so(so),
        .o_so_oe(so_oe), .o_protect_flags(flags),
        .o_protect_flags_lock(lock), .o_write_enable_latch(write_enable_latch));
    spi_host_model i_host (.i_clk_sys(clk), .i_so(so), .i_so_oe(so_oe),
        .o_sck(sck), .o_cs_n(cs_n), .o_si(si));
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Expected status byte from the tracked state and the pin levels
    function automatic logic [7:0] exp_st();
        logic [1:0] s;
        s = (&exp_flags) ? `SUMMARY_ALL : ((|exp_flags) ? `SUMMARY_SOME
            : `SUMMARY_NONE);
        return {exp_lock, 1'b0, fail, guard_n, s, exp_wel, busy};
    endfunction
    task automatic state_chk;
        check({lock, flags, write_enable_latch}, {exp_lock, exp_flags, exp_wel});
    endtask
    task automatic wr_en;
        i_host.run(8, {56'h0, `OP_WRITE_ENABLE}, rx);
        exp_wel = 1'b1;
    endtask
    task automatic wr_status(input logic [7:0] v, input logic en);
        if (en)
            wr_en();
        i_host.run(16, {48'h0, `OP_WRITE_STATUS, v}, rx);
        if (exp_wel && !(exp_lock && !guard_n)) begin
            if (!exp_lock && v[5:2] == `GLOBAL_UNPROTECT)
                exp_flags = '0;
            if (!exp_lock && v[5:2] == `GLOBAL_PROTECT)
                exp_flags = '1;
            exp_lock = v[7];
        end
        exp_wel = 1'b0;
        state_chk();
    endtask
    // Busy and fail move mid-frame so the second byte must be fresh
    task automatic rd_status;
        logic [7:0] old;
        old = exp_st();
        fork
            i_host.run(24, {40'h0, `OP_READ_STATUS, 16'h0}, rx);
            begin
                repeat (11 * (8 + i_host.slow)) @(posedge clk);
                busy <= 1'($urandom);
                fail <= 1'($urandom);
            end
        join
        check(rx[15:8] & 8'hDE, old & 8'hDE);
        check(rx[7:0], exp_st());
    endtask
    task automatic rd_sector(input logic [23:0] a);
        i_host.run(48, {16'h0, `OP_READ_PROT, a, 16'h0}, rx);
        check(rx[15:0], {16{exp_flags[a[23:20]]}});
    endtask
    // Frames cut short k bits past a byte boundary, mid-byte unless k is 0
    task automatic abort(input int k);
        i_host.run(8 + k, {56'h0, `OP_READ_STATUS} << k, rx);
        check(so_oe, 1'b0);
        i_host.run(40 + k, {24'h0, `OP_READ_PROT, 32'h0} << k, rx);
        check(so_oe, 1'b0);
        wr_en();
        i_host.run(8 + k, {56'h0, `OP_WRITE_STATUS} << k, rx);
        exp_wel = 1'b0;
        state_chk();
    endtask
    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        exp_lock = 1'b0;
        exp_flags = '1;
        exp_wel = 1'b0;
        state_chk();
    endtask
    // Watchdog: a hang counts as a mismatch
    initial begin
        #2000000;
        n_mismatch++;
        finish_test();
    end
    initial begin
        void'($urandom(32'h2A425202));
        do_reset();
        wr_en();
        rd_status();
        foreach (cor[i]) begin
            wr_status(cor[i], 1'b1);
            rd_status();
        end
        guard_n <= 1'b0;
        repeat (4) @(posedge clk);
        wr_status(8'h00, 1'b1);
        rd_sector(24'hA00000);
        do_reset();
        repeat (30) begin
            guard_n <= 1'($urandom);
            i_host.slow = $urandom % 3;
            repeat (4) @(posedge clk);
            case ($urandom % 4)
                0: wr_status(8'($urandom), 1'($urandom));
                1: rd_status();
                2: rd_sector(24'($urandom));
                default: abort($urandom % 8);
            endcase
        end
        finish_test();
    end
endmodule // flash_protection_status_tb_top
`default_nettype wire
